// ---- hdl/ebh_params.svh ----
// Timing and field constants for the external bus handover block.
`ifndef EBH_PARAMS_SVH
`define EBH_PARAMS_SVH
`define EBH_SYNC_STAGES 2
`define EBH_ON_N 1'b0
`define EBH_OFF_N 1'b1
`endif

// ---- hdl/ebh_pkg.sv ----
// Types shared by the external bus handover block.
package ebh_pkg;
   // Memory strobes of the external interface, all active low.
   typedef struct packed
   {
      logic program_mem_select_n;
      logic data_mem_select_n;
      logic byte_mem_select_n;
      logic composite_mem_select_n;
      logic io_space_select_n;
      logic read_n;
      logic write_n;
   } ebh_strobe_t;

   // Handover states.
   typedef enum logic [1:0]
   {
      EBH_OWN,
      EBH_GRANTED,
      EBH_HUNG
   } ebh_state_t;
endpackage : ebh_pkg

// ---- hdl/ebh_bus_handover.sv ----
// External bus handover: yields the memory bus to an outside master on request.
// Contract
// R1: Outside master holds bus request low for as long as it wants the bus.
// R2: With no external access active, yield the bus the next cycle and stall.
// R3: While yielding, float address, data and all memory strobes.
// R4: While yielding, drive bus grant low.
// R5: In run-until-external mode keep executing until an external access is needed.
// R6: A request during an external access waits until the cycle after it ends.
// R7: Grant at the end of an access even if its instruction is unfinished.
// R8: Two accesses in one instruction: grant between them.
// R9: On request release drop grant, drive the bus again, resume execution.
// R10: Handover stays active during reset and boot loading.
// R11: Granted and stalled needing external or byte DMA access: assert hung grant.
// R12: Outside master releases the bus to let a stalled device continue.
// R13: After return, drop grant and hung grant, then perform the pending access.
// R14: Emulator enable selects emulator reset, request, grant; normal grant floats.
// R15: During emulator single-step ignore normal reset and normal bus request.
// R16: Bus request is synchronised to the processor clock before use.
`timescale 1ns/1ns
`default_nettype none
`include "ebh_params.svh"

// ==========================================================================
// Pin synchroniser
// ==========================================================================
// A chain of flops on sys_clk. Only the last stage leaves the module, so no
// logic can ever read the metastable first stage.
module ebh_sync
   import ebh_pkg::*;
#(
   parameter int STAGES = 2
)
(
   // Clock and enable.
   input wire logic sys_clk,
   input wire logic clk_en,
   // Asynchronous pin and its synchronised copy.
   input wire logic pin_in,
   output logic pin_sync
);

   logic [STAGES-1:0] sync_q, sync_d;

   // Shift the pin in at the bottom and hand out the top stage.
   always_comb
   begin
      sync_d = {sync_q[STAGES-2:0], pin_in};
      pin_sync = sync_q[STAGES-1];
   end

   // No reset here, so the chain keeps running while the chip is in reset.
   always_ff @(posedge sys_clk)
   begin
      if (clk_en)
      begin
         sync_q <= sync_d;
      end
   end

endmodule : ebh_sync

module ebh_bus_handover
   import ebh_pkg::*;
#(
   parameter int ADDR_W = 14,
   parameter int DATA_W = 24
)
(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Outside master pins.
   input wire logic bus_request_n,
   output logic bus_grant_n,
   output logic bus_grant_oe_n,
   output logic grant_hung_n,
   // Emulator pins.
   input wire logic emulator_enable,
   input wire logic emu_reset_n,
   input wire logic emu_bus_request_n,
   input wire logic emu_single_step,
   output logic emu_bus_grant_n,
   // Core side.
   input wire logic ext_access_busy,
   input wire logic ext_access_needed,
   input wire logic byte_mem_dma,
   input wire logic go_mode,
   output logic core_stall,
   output logic core_reset_n,
   // Core memory interface.
   input wire logic [ADDR_W-1:0] core_addr,
   input wire logic [DATA_W-1:0] core_wdata,
   input wire logic core_data_drive,
   input wire ebh_strobe_t core_strobe,
   // External memory pins, enables low while driven.
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_addr_oe_n,
   output logic [DATA_W-1:0] mem_data_out,
   output logic mem_data_oe_n,
   output ebh_strobe_t mem_strobe,
   output logic mem_strobe_oe_n
);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic breq_s;
   logic ebreq_s;
   logic ee_s;
   logic ss_s;
   logic rst_s;
   logic erst_s;

   // Each pin passes its own chain; the chains keep running through reset.
   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_breq_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(bus_request_n),
      .pin_sync(breq_s)
   ); // [R16] [R10]

   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_ebreq_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(emu_bus_request_n),
      .pin_sync(ebreq_s)
   );

   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_ee_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(emulator_enable),
      .pin_sync(ee_s)
   );

   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_ss_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(emu_single_step),
      .pin_sync(ss_s)
   );

   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_rst_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(reset_n),
      .pin_sync(rst_s)
   );

   ebh_sync #(
      .STAGES(`EBH_SYNC_STAGES)
   )
   i_erst_sync
   (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .pin_in(emu_reset_n),
      .pin_sync(erst_s)
   );

   // ==========================================================================
   // Source selection
   // ==========================================================================
   logic emu_on;
   logic req_active;
   logic ss_on;

   // Emulator mode swaps in the emulator pins; single step masks the normal ones.
   always_comb
   begin
      emu_on = ee_s;
      ss_on = ss_s;
      if (emu_on) // [R14]
      begin
         req_active = (ebreq_s == `EBH_ON_N);
         core_reset_n = erst_s;
      end
      else if (ss_on) // [R15]
      begin
         req_active = 1'b0;
         core_reset_n = `EBH_OFF_N;
      end
      else
      begin
         req_active = (breq_s == `EBH_ON_N); // [R1]
         core_reset_n = rst_s;
      end
   end

   // ==========================================================================
   // Handover state machine
   // ==========================================================================
   // The state is deliberately not cleared by the chip reset while a request is pending: the request
   // logic must keep serving an outside master while the core is in reset.
   // Only the first sys_clk edge needs a defined value, so reset_n clears it
   // only when no request is pending.
   ebh_state_t state_q, state_d;
   logic granted;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         EBH_OWN:
         begin
            // Grant only between accesses, so an access never breaks mid-way.
            if (req_active && !ext_access_busy) // [R2] [R6] [R7] [R8]
            begin
               state_d = EBH_GRANTED;
            end
         end
         EBH_GRANTED:
         begin
            if (!req_active) // [R9]
            begin
               state_d = EBH_OWN;
            end
            else if (ext_access_needed || byte_mem_dma) // [R11]
            begin
               state_d = EBH_HUNG;
            end
         end
         EBH_HUNG:
         begin
            if (!req_active) // [R12] [R13]
            begin
               state_d = EBH_OWN;
            end
         end
         default:
         begin
            state_d = EBH_OWN;
         end
      endcase
   end

   // Reset also waits for the enable, so a low enable freezes every flop.
   always_ff @(posedge sys_clk)
   begin
      if (clk_en)
      begin
         if (!reset_n && !req_active) // [R10]
         begin
            state_q <= EBH_OWN;
         end
         else
         begin
            state_q <= state_d;
         end
      end
   end

   // ==========================================================================
   // Pin and core outputs
   // ==========================================================================
   logic grant_q, grant_d;
   logic hung_q, hung_d;

   always_comb
   begin
      granted = (state_q != EBH_OWN);
      grant_d = (state_d != EBH_OWN);
      hung_d = (state_d == EBH_HUNG);
   end

   // Grant and hung flags are registered so the pins change cleanly.
   always_ff @(posedge sys_clk)
   begin
      if (clk_en)
      begin
         if (!reset_n && !req_active)
         begin
            grant_q <= 1'b0;
            hung_q <= 1'b0;
         end
         else
         begin
            grant_q <= grant_d;
            hung_q <= hung_d;
         end
      end
   end

   // Grant always drives bus_grant_n, floated in emulator mode; emu_bus_grant_n carries it only in emulator mode and reads high otherwise.
   always_comb
   begin
      bus_grant_n = grant_q ? `EBH_ON_N : `EBH_OFF_N; // [R4]
      emu_bus_grant_n = (grant_q && emu_on) ? `EBH_ON_N : `EBH_OFF_N;
      bus_grant_oe_n = emu_on; // [R14]
      grant_hung_n = hung_q ? `EBH_ON_N : `EBH_OFF_N; // [R11] [R13]
      // Go mode lets the core run on until it needs the external bus.
      // Byte DMA runs beside the core, so in go mode only a core access stops execution.
      core_stall = granted && (!go_mode || ext_access_needed); // [R2] [R5]
   end

   // Outputs float while the bus is granted away and drive again on return.
   always_comb
   begin
      mem_addr = core_addr;
      mem_data_out = core_wdata;
      mem_strobe = core_strobe;
      mem_addr_oe_n = grant_q; // [R3] [R9]
      mem_strobe_oe_n = grant_q; // [R3]
      mem_data_oe_n = grant_q || !core_data_drive; // [R3]
   end

endmodule : ebh_bus_handover
`default_nettype wire

// ---- test/ebh_monitor.sv ----
// Port checker for the external bus handover block.
`timescale 1ns/1ns
`default_nettype none
module ebh_monitor (
   // Watched ports.
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic bus_request_n,
   input wire logic bus_grant_n,
   input wire logic bus_grant_oe_n,
   input wire logic grant_hung_n,
   input wire logic emulator_enable,
   input wire logic ext_access_busy,
   input wire logic ext_access_needed,
   input wire logic go_mode,
   input wire logic core_stall,
   input wire logic mem_addr_oe_n,
   input wire logic mem_data_oe_n,
   input wire logic mem_strobe_oe_n
);
   // ==========
   // Relations on the processor clock; the windows allow for the request synchroniser.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   a_grant_floats: assert property (!bus_grant_n |-> mem_addr_oe_n && mem_data_oe_n && mem_strobe_oe_n)
      else $error("bus driven while granted");
   a_idle_grant: assert property ((!bus_request_n && !ext_access_busy && !emulator_enable)[*6] |-> !bus_grant_n)
      else $error("grant missing");
   a_busy_hold: assert property ((bus_grant_n && ext_access_busy)[*2] |=> bus_grant_n)
      else $error("grant during access");
   a_release_back: assert property ((bus_request_n && !emulator_enable)[*6] |-> bus_grant_n && grant_hung_n)
      else $error("grant kept after release");
   a_rise_drives: assert property ($rose(bus_grant_n) |-> !mem_addr_oe_n && grant_hung_n)
      else $error("bus not driven back");
   a_go_runs: assert property (go_mode && !ext_access_needed |-> !core_stall)
      else $error("stall in go mode");
   a_stall_held: assert property ((!bus_request_n && !bus_grant_n)[*4] ##0 !go_mode |-> core_stall)
      else $error("no stall while granted");
   a_hung_set: assert property ((!bus_grant_n && ext_access_needed && !bus_request_n)[*3] |-> !grant_hung_n)
      else $error("hung grant missing");
   a_hung_only: assert property (!grant_hung_n |-> !bus_grant_n)
      else $error("hung without grant");
   a_emu_float: assert property (emulator_enable[*4] |-> bus_grant_oe_n)
      else $error("grant pin driven in emulation");
   c_granted: cover property (!bus_grant_n && ext_access_busy);
   c_hung: cover property (!grant_hung_n);
   c_back: cover property ($rose(bus_grant_n));
endmodule : ebh_monitor
`default_nettype wire

// ---- test/ebh_master.sv ----
// Behavioural outside master that asks for the memory bus.
`timescale 1ns/1ns
`default_nettype none
module ebh_master (
   // Clock and bench wish.
   input wire logic sys_clk,
   input wire logic want,
   // Request pin.
   output logic bus_request_n
);
   // ==========
   // Request stays low while the bus is wanted, and is dropped so a stalled device can go on.
   initial bus_request_n = 1'b1;
   always @(negedge sys_clk)
      bus_request_n <= !want;
endmodule : ebh_master
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the external bus handover block.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import ebh_pkg::*;
   // ==========
   // Signals, counters and the model's grant state.
   logic sys_clk = 0, reset_n = 0, want = 1, emulator_enable = 0, emu_bus_request_n = 1;
   logic ext_access_busy = 0, ext_access_needed = 0, byte_mem_dma = 0, go_mode = 0, core_data_drive = 1;
   logic [13:0] core_addr = 0, mem_addr;
   logic [23:0] core_wdata = 0;
   ebh_strobe_t core_strobe = '1;
   logic bus_request_n, bus_grant_n, bus_grant_oe_n, grant_hung_n, emu_bus_grant_n, core_stall;
   logic mem_addr_oe_n, mem_data_oe_n, mem_strobe_oe_n;
   int n_fail = 0, total_checks = 0, g = 1, h = 0;
   initial forever #2 sys_clk = ~sys_clk;
   ebh_bus_handover i_dut (.sys_clk, .reset_n, .clk_en(1'b1), .bus_request_n, .bus_grant_n, .bus_grant_oe_n,
      .grant_hung_n, .emulator_enable, .emu_reset_n(1'b1), .emu_bus_request_n, .emu_single_step(1'b0),
      .emu_bus_grant_n, .ext_access_busy, .ext_access_needed, .byte_mem_dma, .go_mode, .core_stall,
      .core_reset_n(), .core_addr, .core_wdata, .core_data_drive, .core_strobe, .mem_addr, .mem_addr_oe_n,
      .mem_data_out(), .mem_data_oe_n, .mem_strobe(), .mem_strobe_oe_n);
   ebh_master i_master (.sys_clk, .want, .bus_request_n);
   // One comparison, counted.
   task automatic chk(string name, logic got, logic exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s exp %b got %b", name, exp, got);
      end
   endtask : chk
   // Holds one input set for eight cycles, so the synchroniser settles, then compares with the model.
   task automatic step(bit rq, bit busy, bit need, bit go);
      @(negedge sys_clk);
      want = rq;
      ext_access_busy = busy;
      ext_access_needed = need;
      go_mode = go;
      byte_mem_dma = bit'($urandom);
      core_addr = 14'($urandom);
      core_wdata = 24'($urandom);
      repeat (8) @(negedge sys_clk);
      g = !rq ? 0 : (!busy ? 1 : g);
      h = g && (h || need || byte_mem_dma);
      chk("grant", bus_grant_n, !g);
      chk("addr_oe", mem_addr_oe_n, g[0]);
      chk("stall", core_stall, g && (!go || need));
      chk("hung", grant_hung_n, !h);
      chk("addr", mem_addr === core_addr || g, 1'b1);
   endtask : step
   // Prints the verdict and stops.
   task automatic complete_run;
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   // Main sequence; the request is already pending while reset is held.
   initial
   begin
      void'($urandom(32'hc51afb31));
      repeat (5) @(negedge sys_clk);
      chk("reset_grant", bus_grant_n, 1'b0);
      reset_n = 1;
      step(1, 1, 0, 0);
      step(0, 0, 0, 0);
      step(1, 1, 0, 0);
      step(1, 0, 0, 0);
      step(1, 1, 0, 0);
      step(1, 0, 1, 0);
      step(1, 0, 0, 1);
      step(1, 0, 1, 1);
      step(0, 0, 1, 0);
      reset_n = 0;
      step(1, 0, 0, 0);
      reset_n = 1;
      repeat (20) step(bit'($urandom), bit'($urandom), bit'($urandom), bit'($urandom));
      step(0, 0, 0, 0);
      emulator_enable = 1;
      emu_bus_request_n = 0;
      repeat (8) @(negedge sys_clk);
      chk("grant_oe", bus_grant_oe_n, 1'b1);
      chk("emu_grant", emu_bus_grant_n, 1'b0);
      complete_run;
   end
   // Watchdog: the sequence needs under 1500 ns, so this span only runs out on a hang.
   initial
   begin
      #20000;
      n_fail++;
      complete_run;
   end
endmodule : tb
bind ebh_bus_handover ebh_monitor i_mon (.sys_clk, .reset_n, .bus_request_n, .bus_grant_n, .bus_grant_oe_n,
   .grant_hung_n, .emulator_enable, .ext_access_busy, .ext_access_needed, .go_mode, .core_stall,
   .mem_addr_oe_n, .mem_data_oe_n, .mem_strobe_oe_n);
`default_nettype wire
